// file: logic/mbts_pkg.sv
`default_nettype none
// Shared constants of the board trigger and timebase sync block
package mbts_pkg;
	// Clock rates and the internal base clock divider
	localparam int SYS_CLK_HZ = 200_000_000;
	localparam int BASE_CLK_HZ = 20_000_000;
	localparam int BASE_DIV = SYS_CLK_HZ / BASE_CLK_HZ;
	// Exported trigger stays on its line for this many system cycles
	localparam logic [3:0] EXPORT_LEN = 4'h8;
	// Pin counts
	localparam int NUM_PFI = 10;
	localparam int NUM_LINES = 8;
	localparam int NUM_TRIG_LINES = 7;
	localparam int TB_LINE = 7;
	// Register bus geometry
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_SRC = 5'h04;
	localparam logic [4:0] OFF_CMD = 5'h08;
	localparam logic [4:0] OFF_STAT = 5'h0C;
	// Control register fields
	localparam int CTRL_EXT = 0;
	localparam int CTRL_DRV = 1;
	localparam int CTRL_ARM = 2;
	localparam int CTRL_FALL = 3;
	localparam int CTRL_TO_AO = 4;
	localparam int CTRL_TO_CTR = 5;
	localparam int CTRL_EXPORT = 6;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// Source register fields
	localparam int SRC_SEL_LSB = 0;
	localparam int SRC_SEL_W = 5;
	localparam int SRC_EXP_LSB = 8;
	localparam int SRC_EXP_W = 3;
	localparam logic [31:0] SRC_RST = 32'h0000_0000;
	// Command and status fields
	localparam int CMD_SW = 0;
	localparam int STAT_EXT = 0;
	localparam int STAT_DRV = 1;
	localparam int STAT_CNT_LSB = 16;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// file: logic/mbts_det_if.sv
`default_nettype none
// Edge detector hookup: input level, sample enable, pulse back
interface mbts_det_if;
	logic din; // Raw level, asynchronous to the detector clock
	logic en; // Sample enable
	logic pulse; // One-cycle edge pulse
	modport det (input din, input en, output pulse);
	modport user (output din, output en, input pulse);
endinterface
`default_nettype wire

// file: logic/mbts_edge_det.sv
`default_nettype none
// Two-stage synchroniser followed by a rising edge detector
module mbts_edge_det (
	input wire logic clk,
	input wire logic rst,
	mbts_det_if.det det
);
	import mbts_pkg::*;

	logic s1_r, s1_nxt; // First sync stage
	logic s2_r, s2_nxt; // Second sync stage
	logic s3_r, s3_nxt; // Previous settled level
	logic pulse_r, pulse_nxt; // Edge pulse

	// Next values: shift only on enabled samples
	always_comb begin
		s1_nxt = s1_r;
		s2_nxt = s2_r;
		s3_nxt = s3_r;
		pulse_nxt = 1'b0;
		if (det.en) begin
			s1_nxt = det.din;
			s2_nxt = s1_r;
			s3_nxt = s2_r;
			pulse_nxt = s2_r & ~s3_r;
		end
	end

	// Registers
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			pulse_r <= 1'b0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign det.pulse = pulse_r;

	chk_edge_rise: assert property (@(posedge clk) disable iff (rst)
		det.en && s2_r && !s3_r |=> det.pulse)
		else $error("settled rise gave no pulse");
	chk_pulse_once: assert property (@(posedge clk) disable iff (rst)
		det.pulse |=> !det.pulse)
		else $error("edge pulse longer than one cycle");
endmodule // mbts_edge_det
`default_nettype wire

// file: logic/mbts_sync_top.sv
// Function
// - one master board supplies the shared timebase
// - slave takes timebase from sync line 7
// - master exports shared trigger on a free line
// - triggers from software or external digital signal
// - source is any function pin or line 0..6
// - rising or falling edge selects the trigger
// - trigger routed to output sequencer or counters
// - timebase only on dedicated line 7
// - reset: internal clock, not driven; drive gated
`default_nettype none
module mbts_sync_top #(
	parameter int NUM_PFI = mbts_pkg::NUM_PFI,
	parameter int BASE_DIV = mbts_pkg::BASE_DIV
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic clk_shared_tb,
	input wire logic [NUM_PFI-1:0] prog_function_pins,
	input wire logic [mbts_pkg::NUM_LINES-1:0] board_sync_bus_i,
	output logic [mbts_pkg::NUM_LINES-1:0] board_sync_bus_o,
	output logic [mbts_pkg::NUM_LINES-1:0] board_sync_bus_oe,
	output logic trig_ao,
	output logic trig_ctr,
	input wire logic [mbts_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [mbts_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import mbts_pkg::*;

	localparam int SRC_N = NUM_PFI + NUM_TRIG_LINES; // Selectable sources
	localparam int DIV_W = $clog2(BASE_DIV);

	// Elaboration checks
	if (BASE_DIV < 2 || (BASE_DIV % 2) != 0) begin : g_bad_div
		$error("BASE_DIV must be even and at least 2");
	end
	if (SRC_N > 31 || NUM_PFI < 1) begin : g_bad_pfi
		$error("NUM_PFI out of range for the source field");
	end

	// Bus slave state
	logic [31:0] ctrl_r, ctrl_nxt; // Control
	logic [31:0] src_r, src_nxt; // Source and export line
	logic aw_hold_r, aw_hold_nxt; // Write address held
	logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic w_hold_r, w_hold_nxt; // Write data held
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	// Timebase and trigger state
	logic [DIV_W-1:0] div_cnt_r, div_cnt_nxt; // Base clock divider
	logic base_clk_r, base_clk_nxt; // Internal base clock
	logic [3:0] exp_cnt_r, exp_cnt_nxt; // Export stretch
	logic trig_ao_r, trig_ao_nxt;
	logic trig_ctr_r, trig_ctr_nxt;
	logic [15:0] trig_cnt_r, trig_cnt_nxt; // Triggers fired
	logic [NUM_LINES-1:0] bus_o_r, bus_o_nxt;
	logic [NUM_LINES-1:0] bus_oe_r, bus_oe_nxt;
	// Crossing flops, link events into the system domain
	logic tg1_r, tg2_r, tg3_r;
	// Link domain flops
	logic rst_l1_r, rst_l2_r; // Reset synchroniser
	logic ce_l1_r, ce_l2_r; // Enable synchroniser
	logic tgl_r, tgl_nxt; // Event toggle

	// Combinational helpers
	logic base_tick; // One cycle per base clock period
	logic sw_go; // Software trigger written
	logic hw_evt; // Detected external edge
	logic link_evt; // Edge seen on the shared timebase
	logic fire; // Trigger accepted
	logic sel_valid;
	logic raw_pol; // Selected level, polarity applied
	logic [SRC_N-1:0] src_vec;
	logic [SRC_SEL_W-1:0] sel;
	logic [SRC_EXP_W-1:0] exp_line;
	logic do_wr;

	mbts_det_if int_if ();
	mbts_det_if link_if ();

	// Source selection over pins and trigger lines 0..6
	assign src_vec = {board_sync_bus_i[NUM_TRIG_LINES-1:0], prog_function_pins};
	assign sel = src_r[SRC_SEL_LSB +: SRC_SEL_W];
	assign sel_valid = sel < SRC_SEL_W'(SRC_N);
	// Falling edge turned into a rising one before sync
	assign raw_pol = (sel_valid ? src_vec[sel] : 1'b0) ^ ctrl_r[CTRL_FALL];

	// Detector on the internal base clock
	assign int_if.din = raw_pol;
	assign int_if.en = ce & base_tick;
	mbts_edge_det u_int_det (
		.clk(clk_sys),
		.rst(sys_rst),
		.det(int_if.det)
	);

	// Detector on the shared timebase from line 7
	assign link_if.din = raw_pol;
	assign link_if.en = ce_l2_r;
	mbts_edge_det u_link_det (
		.clk(clk_shared_tb),
		.rst(rst_l2_r),
		.det(link_if.det)
	);

	// Link domain next value
	always_comb begin
		tgl_nxt = tgl_r ^ link_if.pulse;
	end

	// Link domain registers; sync chains run freely
	always_ff @(posedge clk_shared_tb) begin
		rst_l1_r <= sys_rst;
		rst_l2_r <= rst_l1_r;
		ce_l1_r <= ce;
		ce_l2_r <= ce_l1_r;
		if (rst_l2_r) begin
			tgl_r <= 1'b0;
		end else if (ce_l2_r) begin
			tgl_r <= tgl_nxt;
		end
	end

	// Event selection by timebase choice
	assign base_tick = (div_cnt_r == '0);
	assign link_evt = tg2_r ^ tg3_r;
	assign hw_evt = ctrl_r[CTRL_EXT] ? link_evt : int_if.pulse;
	assign exp_line = src_r[SRC_EXP_LSB +: SRC_EXP_W];

	// Handshake outputs, gated so a frozen cycle takes nothing
	assign s_axi_awready = ce & ~aw_hold_r & ~bvalid_r;
	assign s_axi_wready = ce & ~w_hold_r & ~bvalid_r;
	assign s_axi_bvalid = ce & bvalid_r;
	assign s_axi_arready = ce & ~rvalid_r;
	assign s_axi_rvalid = ce & rvalid_r;
	assign do_wr = aw_hold_r & w_hold_r & ~bvalid_r;

	// Next values of the system domain
	always_comb begin
		ctrl_nxt = ctrl_r;
		src_nxt = src_r;
		aw_hold_nxt = aw_hold_r;
		awaddr_nxt = awaddr_r;
		w_hold_nxt = w_hold_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		sw_go = 1'b0;
		// Address and data captured in either order
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		// Write once both halves are in
		if (do_wr) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = RESP_OKAY;
			case (awaddr_r)
				OFF_CTRL: begin
					for (int b = 0; b < 4; b++) begin
						if (wstrb_r[b]) ctrl_nxt[8*b +: 8] = wdata_r[8*b +: 8];
					end
				end
				OFF_SRC: begin
					for (int b = 0; b < 4; b++) begin
						if (wstrb_r[b]) src_nxt[8*b +: 8] = wdata_r[8*b +: 8];
					end
				end
				OFF_CMD: begin
					sw_go = wstrb_r[0] & wdata_r[CMD_SW];
				end
				OFF_STAT: begin
					bresp_nxt = RESP_OKAY; // Read-only, write ignored
				end
				default: begin
					bresp_nxt = RESP_SLVERR;
				end
			endcase
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		// Read answer
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			case (s_axi_araddr)
				OFF_CTRL: rdata_nxt = ctrl_r;
				OFF_SRC: rdata_nxt = src_r;
				OFF_CMD: rdata_nxt = 32'h0000_0000;
				OFF_STAT: begin
					rdata_nxt[STAT_EXT] = ctrl_r[CTRL_EXT];
					rdata_nxt[STAT_DRV] = bus_oe_r[TB_LINE];
					rdata_nxt[STAT_CNT_LSB +: 16] = trig_cnt_r;
				end
				default: rresp_nxt = RESP_SLVERR;
			endcase
		end
	end

	// Trigger, divider and pin drive next values
	always_comb begin
		div_cnt_nxt = (div_cnt_r == DIV_W'(BASE_DIV - 1)) ? '0 : div_cnt_r + 1'b1;
		base_clk_nxt = base_clk_r;
		if (div_cnt_r == '0) base_clk_nxt = 1'b1;
		if (div_cnt_r == DIV_W'(BASE_DIV / 2)) base_clk_nxt = 1'b0;
		// Nothing fires until armed
		fire = ctrl_r[CTRL_ARM] & (sw_go | hw_evt);
		trig_ao_nxt = fire & ctrl_r[CTRL_TO_AO];
		trig_ctr_nxt = fire & ctrl_r[CTRL_TO_CTR];
		trig_cnt_nxt = trig_cnt_r + {15'h0000, fire};
		exp_cnt_nxt = fire ? EXPORT_LEN : (exp_cnt_r != 4'h0 ? exp_cnt_r - 4'h1 : 4'h0);
		bus_o_nxt = '0;
		bus_oe_nxt = '0;
		// Shared trigger on the chosen free line
		for (int k = 0; k < NUM_TRIG_LINES; k++) begin
			bus_o_nxt[k] = exp_cnt_r != 4'h0;
			bus_oe_nxt[k] = ctrl_r[CTRL_EXPORT] && (exp_line == SRC_EXP_W'(k));
		end
		// Base clock out only on line 7, only from internal source
		bus_o_nxt[TB_LINE] = base_clk_r;
		bus_oe_nxt[TB_LINE] = ctrl_r[CTRL_DRV] & ~ctrl_r[CTRL_EXT];
	end

	// System domain registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ctrl_r <= CTRL_RST;
			src_r <= SRC_RST;
			aw_hold_r <= 1'b0;
			awaddr_r <= '0;
			w_hold_r <= 1'b0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= RESP_OKAY;
			div_cnt_r <= '0;
			base_clk_r <= 1'b0;
			exp_cnt_r <= 4'h0;
			trig_ao_r <= 1'b0;
			trig_ctr_r <= 1'b0;
			trig_cnt_r <= 16'h0000;
			bus_o_r <= '0;
			bus_oe_r <= '0;
			tg1_r <= 1'b0;
			tg2_r <= 1'b0;
			tg3_r <= 1'b0;
		end else if (ce) begin
			ctrl_r <= ctrl_nxt;
			src_r <= src_nxt;
			aw_hold_r <= aw_hold_nxt;
			awaddr_r <= awaddr_nxt;
			w_hold_r <= w_hold_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			div_cnt_r <= div_cnt_nxt;
			base_clk_r <= base_clk_nxt;
			exp_cnt_r <= exp_cnt_nxt;
			trig_ao_r <= trig_ao_nxt;
			trig_ctr_r <= trig_ctr_nxt;
			trig_cnt_r <= trig_cnt_nxt;
			bus_o_r <= bus_o_nxt;
			bus_oe_r <= bus_oe_nxt;
			tg1_r <= tgl_r;
			tg2_r <= tg1_r;
			tg3_r <= tg2_r;
		end
	end

	// Outputs
	assign s_axi_bresp = bresp_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign trig_ao = trig_ao_r;
	assign trig_ctr = trig_ctr_r;
	assign board_sync_bus_o = bus_o_r;
	assign board_sync_bus_oe = bus_oe_r;

	chk_line7_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$past(ce) && bus_oe_r[TB_LINE] |-> $past(ctrl_r[CTRL_DRV]) && !$past(ctrl_r[CTRL_EXT]))
		else $error("timebase driven while not allowed");
	chk_line7_clock: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$past(ce) && bus_oe_r[TB_LINE] |-> bus_o_r[TB_LINE] == $past(base_clk_r))
		else $error("line 7 carries something other than the base clock");
	chk_reset_state: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$past(sys_rst) |-> !bus_oe_r[TB_LINE] && !ctrl_r[CTRL_EXT])
		else $error("reset state not internal and undriven");
	chk_sw_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ce && ctrl_r[CTRL_ARM] && sw_go
		|=> trig_ao_r == $past(ctrl_r[CTRL_TO_AO]) && trig_ctr_r == $past(ctrl_r[CTRL_TO_CTR]))
		else $error("software trigger misrouted");
	chk_unarmed_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(!ctrl_r[CTRL_ARM])[*2] |-> !trig_ao_r && !trig_ctr_r)
		else $error("trigger while unarmed");
	chk_export_line: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$past(ce) && (|bus_oe_r[NUM_TRIG_LINES-1:0]) |-> $past(ctrl_r[CTRL_EXPORT])
		&& $onehot(bus_oe_r[NUM_TRIG_LINES-1:0]))
		else $error("export on wrong or several lines");
	chk_link_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ce && ctrl_r[CTRL_ARM] && ctrl_r[CTRL_EXT] && link_evt
		|=> trig_ao_r == $past(ctrl_r[CTRL_TO_AO]))
		else $error("shared timebase edge lost");
	chk_int_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ce && ctrl_r[CTRL_ARM] && !ctrl_r[CTRL_EXT] && int_if.pulse
		|=> trig_ctr_r == $past(ctrl_r[CTRL_TO_CTR]))
		else $error("internal timebase edge lost");
endmodule // mbts_sync_top
`default_nettype wire

// file: tb/mbts_peer_model.sv
`default_nettype none
// Peer master board on the sync bus: shared timebase and one trigger line
module mbts_peer_model (
	input wire logic [2:0] trig_line,
	input wire logic trig_lvl,
	output logic clk_shared_tb,
	output logic [6:0] lines
);
	timeunit 1ns;
	timeprecision 1ps;
	// Master's base clock, shared to every board on line 7, 48 ns period
	initial begin
		clk_shared_tb = 1'b0;
		#7;
		forever #24 clk_shared_tb = ~clk_shared_tb;
	end
	// Chosen free line carries the trigger; released lines keep changing
	always_comb begin
		for (int k = 0; k < 7; k++) begin
			lines[k] = (3'(k) == trig_line) ? trig_lvl : (clk_shared_tb ^ k[0]);
		end
	end
endmodule // mbts_peer_model
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
// Bench for the board trigger and timebase sync block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import mbts_pkg::*;
	localparam logic [31:0] C_EXT = 32'h1 << CTRL_EXT; // Control bits
	localparam logic [31:0] C_DRV = 32'h1 << CTRL_DRV;
	localparam logic [31:0] C_ARM = 32'h1 << CTRL_ARM;
	localparam logic [31:0] C_FALL = 32'h1 << CTRL_FALL;
	localparam logic [31:0] C_AO = 32'h1 << CTRL_TO_AO;
	localparam logic [31:0] C_CTR = 32'h1 << CTRL_TO_CTR;
	localparam logic [31:0] C_EXP = 32'h1 << CTRL_EXPORT;
	logic clk_sys, sys_rst, ce, trig_ao, trig_ctr, p_lvl, clk_tb;
	logic [9:0] pins;
	logic [2:0] p_line;
	logic [6:0] p_lines;
	logic [7:0] bus_i, bus_o, bus_oe;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	int error_cnt = 0;
	int n_checks = 0;
	int n_ao = 0;
	int n_ctr = 0;
	// Wire level: whoever enables wins the line
	assign bus_i = (bus_oe & bus_o) | (~bus_oe & {clk_tb, p_lines});
	mbts_sync_top i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce),
		.clk_shared_tb(clk_tb), .prog_function_pins(pins), .board_sync_bus_i(bus_i),
		.board_sync_bus_o(bus_o), .board_sync_bus_oe(bus_oe), .trig_ao(trig_ao),
		.trig_ctr(trig_ctr), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	mbts_peer_model i_peer (.trig_line(p_line), .trig_lvl(p_lvl), .clk_shared_tb(clk_tb),
		.lines(p_lines));
	// System clock, 5 ns
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Pulse counters, sampled mid-cycle
	always @(negedge clk_sys) begin
		if (trig_ao === 1'b1) n_ao++;
		if (trig_ctr === 1'b1) n_ctr++;
	end
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Verdict and end of run
	task automatic end_sim;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// A wait ran out
	task automatic tmo;
		error_cnt++;
		$display("mismatch t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
		end_sim();
	endtask
	// Bus write: address and data offered together, each released when taken
	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		int i;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk_sys);
			if (!aw && !w && bvalid === 1'b1) break;
			if (aw && awready === 1'b1) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		if (i == 100) tmo();
		r = bresp;
		bready <= 1'b0;
	endtask
	// Bus read
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar;
		int i;
		ar = 1'b1;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk_sys);
			if (!ar && rvalid === 1'b1) break;
			if (ar && arready === 1'b1) begin
				ar = 1'b0;
				arvalid <= 1'b0;
			end
		end
		if (i == 100) tmo();
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// Reset state, register defaults and two unmapped places
	task automatic s_reset;
		logic [31:0] d;
		logic [1:0] r;
		chk(32'(bus_oe), 32'h0);
		rd(OFF_CTRL, d, r);
		chk(d, CTRL_RST);
		rd(OFF_SRC, d, r);
		chk(d, SRC_RST);
		wr(5'h10, 32'hFFFF_FFFF, r);
		chk(32'(r), 32'(RESP_SLVERR));
		rd(5'h14, d, r);
		chk({d[29:0], r}, {30'h0, RESP_SLVERR});
	endtask
	// Software trigger, routing and arming
	task automatic s_sw(input logic [31:0] ctrl, input int e_ao, input int e_ctr);
		logic [1:0] r;
		int a, c;
		wr(OFF_CTRL, ctrl, r);
		a = n_ao;
		c = n_ctr;
		wr(OFF_CMD, 32'h1, r);
		repeat (4) @(posedge clk_sys);
		chk(32'(n_ao - a), 32'(e_ao));
		chk(32'(n_ctr - c), 32'(e_ctr));
	endtask
	// Trigger exported on one free sync line
	task automatic s_export;
		logic [1:0] r;
		wr(OFF_SRC, 32'h3 << SRC_EXP_LSB, r);
		wr(OFF_CTRL, C_ARM | C_EXP, r);
		wr(OFF_CMD, 32'h1, r);
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk(32'({bus_oe[3], bus_o[3], bus_oe[2]}), 32'h6);
	endtask
	// Base clock driven on line 7 only with internal timebase
	task automatic s_drv;
		logic [31:0] d;
		logic [1:0] r;
		logic [3:0] h;
		wr(OFF_CTRL, C_DRV, r);
		@(negedge clk_sys);
		chk(32'(bus_oe), 32'h80);
		// Base clock on line 7: half of any ten cycles high
		h = 4'h0;
		repeat (10) begin
			@(negedge clk_sys);
			h = h + {3'h0, bus_o[7]};
		end
		chk(32'(h), 32'h5);
		rd(OFF_STAT, d, r);
		chk(32'({d[STAT_DRV], r}), 32'h4);
		// Three armed software triggers so far
		chk(32'(d[STAT_CNT_LSB +: 16]), 32'h3);
		wr(OFF_CTRL, C_DRV | C_EXT, r);
		@(negedge clk_sys);
		chk(32'(bus_oe), 32'h0);
	endtask
	// Mid-run reset drops the drive and clears the registers
	task automatic s_rst_mid;
		logic [31:0] d;
		logic [1:0] r;
		wr(OFF_CTRL, C_DRV | C_ARM, r);
		@(negedge clk_sys);
		chk(32'(bus_oe), 32'h80);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		// Long enough for the link side to clear too
		repeat (40) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(negedge clk_sys);
		chk(32'(bus_oe), 32'h0);
		rd(OFF_CTRL, d, r);
		chk(d, CTRL_RST);
		rd(OFF_STAT, d, r);
		chk(d, 32'h0);
	endtask
	// Drive one trigger source to a level
	task automatic lvl(input int src, input logic v);
		@(posedge clk_sys);
		if (src < 10) pins[src] <= v;
		else begin
			p_line <= 3'(src - 10);
			p_lvl <= v;
		end
	endtask
	// External edge: one pulse on the chosen edge, none on the other
	task automatic s_hw(input int src, input logic fall, input logic ext);
		logic [1:0] r;
		int b, i;
		lvl(src, fall);
		wr(OFF_SRC, (32'h7 << SRC_EXP_LSB) | 32'(src), r);
		wr(OFF_CTRL, C_ARM | C_AO | (fall ? C_FALL : 0) | (ext ? C_EXT : 0), r);
		repeat (80) @(posedge clk_sys);
		b = n_ao;
		lvl(src, !fall);
		for (i = 0; i < 200 && n_ao == b; i++) @(posedge clk_sys);
		if (i == 200) tmo();
		repeat (40) @(posedge clk_sys);
		chk(32'(n_ao - b), 32'h1);
		lvl(src, fall);
		repeat (80) @(posedge clk_sys);
		chk(32'(n_ao - b), 32'h1);
	endtask
	// Main sequence
	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		pins = '0;
		p_line = 3'h0;
		p_lvl = 1'b0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		s_reset();
		s_sw(C_ARM | C_AO | C_CTR, 1, 1);
		s_sw(C_ARM | C_CTR, 0, 1);
		s_sw(C_AO | C_CTR, 0, 0);
		s_export();
		s_drv();
		s_hw(0, 1'b0, 1'b0);
		s_hw(9, 1'b1, 1'b0);
		s_hw(10, 1'b0, 1'b1);
		s_hw(16, 1'b1, 1'b1);
		s_rst_mid();
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
